/* File: fbs_engine.sv */
`timescale 1ns/100ps
module fbs_engine import fbs_pkg::*; #(
  parameter int MACROS = 1,
  parameter int MACRO_W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // data ram port, read data one cycle after ram_re
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [7:0] ram_rdata,
  // flash macro port, read data one cycle after fl_rd
  output logic fl_rd,
  output fbs_fcmd_type fl_cmd,
  output logic fl_pulse,
  output fbs_row_type fl_row,
  output logic [MACRO_W-1:0] fl_macro,
  output logic [7:0] fl_block,
  output logic [5:0] fl_byte,
  output logic [7:0] fl_wdata,
  input wire logic [7:0] fl_rdata,
  // processor state
  output logic cpu_run,
  output logic cpu_halted
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRM, S_DECIDE, S_PROT_RD, S_PROT_CHK, S_RD_XFER, S_WR_RD, S_WR_LD,
    S_PULSE, S_ALL_NEXT, S_BOOT, S_BOOT_CHK, S_RC_K1, S_RC_K2, S_HALT
  } fbs_state_type;

  fbs_state_type state_r;
  logic [7:0] acc_r;
  logic [7:0] sp_r;
  logic [7:0] fn_r;
  logic [7:0] prm_r [0:7];
  logic [2:0] prm_iss_r;
  logic [2:0] prm_cap_r;
  logic [6:0] iss_idx_r;
  logic [5:0] out_idx_r;
  logic [15:0] sum_r;
  logic [15:0] ref_r;
  logic [7:0] rc_r;
  logic halt_after_r;
  logic hw_boot_r;
  logic soft_boot_r;
  logic rd_vld_r;
  logic ram_vld_r;
  logic tmr_start_r;
  logic [1:0] lvl_r;
  logic [3:0] perm_r;
  logic all_pass_r;
  logic [1:0] all_step_r;
  logic [MACRO_W-1:0] mac_r;
  logic tmr_done;
  logic fbs_pulse_on;
  // axi slave state
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic rvalid_r;

  // decoded conditions
  wire logic busy = (state_r != S_IDLE) && (state_r != S_HALT);
  wire logic wr_fire = aw_full_r && w_full_r && !bvalid_r;
  wire logic wr_call = wr_fire && (awaddr_r == ADDR_CALL);
  wire logic wr_sp = wr_fire && (awaddr_r == ADDR_SP);
  wire logic wr_hit = (awaddr_r == ADDR_CALL) || (awaddr_r == ADDR_SP);
  wire logic call_go = wr_call && wstrb_r[0] && !busy && !cpu_halted;
  wire logic ar_fire = arvalid && arready;
  wire logic [7:0] second_key_byte_expect = 8'(sp_r + SECOND_KEY_BYTE_OFFSET);
  wire logic keys_ok = (prm_r[PRM_FIRST_KEY_BYTE] == FIRST_KEY_BYTE_VALUE) && (prm_r[PRM_SECOND_KEY_BYTE] == second_key_byte_expect);
  wire logic [7:0] blk = prm_r[PRM_BLK];
  wire logic [7:0] ptr = prm_r[PRM_PTR];
  wire logic [1:0] blk_lvl = fbs_level(fl_rdata, blk[1:0]);
  wire logic [3:0] blk_perm = fbs_perm(blk_lvl);
  wire logic need_sr = (fn_r == FN_READ);
  wire logic allowed = need_sr ? blk_perm[PERM_SR] : blk_perm[PERM_IW];
  wire logic last_mac = (mac_r == '0);
  wire logic [31:0] status_word = {acc_r, 2'b00, lvl_r, perm_r, rc_r, 5'h00,
                                   cpu_run, cpu_halted, busy};

  // axi handshake outputs
  assign awready = !aw_full_r && !bvalid_r;
  assign wready = !w_full_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign fl_pulse = fbs_pulse_on;

  // program and erase pulse timing
  fbs_pulse_timer #(.CNT_W(16)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tmr_start_r),
    .div(prm_r[PRM_CLK]),
    .dly(prm_r[PRM_DLY]),
    .pulse_on(fbs_pulse_on),
    .done(tmr_done)
  );

  // axi write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // axi read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (araddr)
        ADDR_CALL: rdata_r <= {24'h000000, acc_r};
        ADDR_SP: rdata_r <= {24'h000000, sp_r};
        ADDR_STATUS: rdata_r <= status_word;
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // stack pointer register
  always_ff @(posedge aclk) begin
    if (!aresetn) sp_r <= '0;
    else if (wr_sp && wstrb_r[0]) sp_r <= wdata_r[7:0];
  end

  // read data valid one cycle after each request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_vld_r <= 1'b0;
      ram_vld_r <= 1'b0;
    end else begin
      rd_vld_r <= fl_rd;
      ram_vld_r <= ram_re;
    end
  end

  // service sequencer
  always_ff @(posedge aclk) begin
    fl_rd <= 1'b0;
    ram_we <= 1'b0;
    ram_re <= 1'b0;
    tmr_start_r <= 1'b0;
    if (!aresetn) begin
      state_r <= S_IDLE;
      acc_r <= FN_BOOT;
      hw_boot_r <= 1'b1;
      soft_boot_r <= 1'b0;
      fn_r <= FN_BOOT;
      for (int i = 0; i < 8; i++) prm_r[i] <= '0;
      prm_iss_r <= '0;
      prm_cap_r <= '0;
      iss_idx_r <= '0;
      out_idx_r <= '0;
      sum_r <= '0;
      ref_r <= '0;
      rc_r <= RC_OK;
      halt_after_r <= 1'b0;
      lvl_r <= LVL_OPEN;
      perm_r <= '0;
      all_pass_r <= 1'b0;
      all_step_r <= '0;
      mac_r <= '0;
      cpu_run <= 1'b0;
      cpu_halted <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= '0;
      fl_cmd <= FC_NONE;
      fl_row <= ROW_USER;
      fl_macro <= '0;
      fl_block <= '0;
      fl_byte <= '0;
      fl_wdata <= '0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          iss_idx_r <= '0;
          out_idx_r <= '0;
          prm_iss_r <= '0;
          prm_cap_r <= '0;
          sum_r <= '0;
          if (hw_boot_r) begin
            hw_boot_r <= 1'b0;
            soft_boot_r <= 1'b0;
            fn_r <= FN_BOOT;
            state_r <= S_BOOT;
          end else if (call_go) begin
            acc_r <= wdata_r[7:0];
            fn_r <= wdata_r[7:0];
            cpu_run <= 1'b0;
            soft_boot_r <= 1'b1;
            // code 00h skips keys and parameters
            state_r <= (wdata_r[7:0] == FN_BOOT) ? S_BOOT : S_PRM;
          end
        end
        // fetch the eight parameter bytes
        S_PRM: begin
          if (prm_iss_r != PRM_LAST || !ram_re) begin
            if (iss_idx_r == '0) begin
              ram_re <= 1'b1;
              ram_addr <= 8'(PRM_BASE + {5'h00, prm_iss_r});
              if (prm_iss_r == PRM_LAST) iss_idx_r <= 7'h01;
              else prm_iss_r <= prm_iss_r + 3'h1;
            end
          end
          if (ram_vld_r) begin
            prm_r[prm_cap_r] <= ram_rdata;
            prm_cap_r <= prm_cap_r + 3'h1;
            if (prm_cap_r == PRM_LAST) begin
              iss_idx_r <= '0;
              state_r <= S_DECIDE;
            end
          end
        end
        S_DECIDE: begin
          if (!keys_ok) begin
            state_r <= S_HALT;
          end else begin
            unique case (fn_r)
              FN_READ, FN_WRITE, FN_ERASE: state_r <= S_PROT_RD;
              FN_ERASE_ALL: begin
                all_pass_r <= 1'b0;
                all_step_r <= '0;
                mac_r <= MACRO_W'(MACROS - 1); // highest macro first
                fl_macro <= MACRO_W'(MACROS - 1);
                fl_cmd <= FC_ERASE_USER;
                tmr_start_r <= 1'b1;
                state_r <= S_PULSE;
              end
              default: state_r <= S_HALT;
            endcase
          end
        end
        // look up the block's protection byte
        S_PROT_RD: begin
          fl_rd <= 1'b1;
          fl_cmd <= FC_READ;
          fl_row <= ROW_PROT;
          fl_macro <= '0;
          fl_block <= '0;
          fl_byte <= blk[7:2];
          state_r <= S_PROT_CHK;
        end
        S_PROT_CHK: if (rd_vld_r) begin
          lvl_r <= blk_lvl;
          perm_r <= blk_perm;
          fl_row <= ROW_USER;
          fl_block <= blk;
          if (!allowed) begin
            rc_r <= RC_PROT;
            state_r <= S_RC_K1;
          end else if (fn_r == FN_READ) begin
            state_r <= S_RD_XFER;
          end else if (fn_r == FN_WRITE) begin
            state_r <= S_WR_RD;
          end else begin
            fl_cmd <= FC_ERASE_BLK;
            tmr_start_r <= 1'b1;
            state_r <= S_PULSE;
          end
        end
        // flash to ram, pipelined one byte a cycle
        S_RD_XFER: begin
          if (iss_idx_r != BLOCK_BYTES) begin
            fl_rd <= 1'b1;
            fl_cmd <= FC_READ;
            fl_byte <= iss_idx_r[5:0];
            iss_idx_r <= iss_idx_r + 7'h01;
          end
          if (rd_vld_r) begin
            ram_we <= 1'b1;
            ram_addr <= 8'(ptr + {2'b00, out_idx_r});
            ram_wdata <= fl_rdata;
            out_idx_r <= out_idx_r + 6'h01;
            if (out_idx_r == LAST_BYTE) begin
              rc_r <= RC_OK;
              state_r <= S_RC_K1;
            end
          end
        end
        // ram to flash, one program pulse per byte
        S_WR_RD: begin
          ram_re <= 1'b1;
          ram_addr <= 8'(ptr + {2'b00, out_idx_r});
          state_r <= S_WR_LD;
        end
        S_WR_LD: if (ram_vld_r) begin
          fl_wdata <= ram_rdata;
          fl_byte <= out_idx_r;
          fl_cmd <= FC_PROG;
          tmr_start_r <= 1'b1;
          state_r <= S_PULSE;
        end
        S_PULSE: if (tmr_done) begin
          if (fn_r == FN_ERASE_ALL) begin
            state_r <= S_ALL_NEXT;
          end else if (fn_r == FN_WRITE && out_idx_r != LAST_BYTE) begin
            out_idx_r <= out_idx_r + 6'h01;
            state_r <= S_WR_RD;
          end else begin
            rc_r <= RC_OK;
            state_r <= S_RC_K1;
          end
        end
        // step through the full erase sequence
        S_ALL_NEXT: begin
          tmr_start_r <= 1'b1;
          state_r <= S_PULSE;
          if (!all_pass_r && all_step_r == 2'h0) begin
            all_step_r <= 2'h1;
            fl_cmd <= FC_ZERO_USER;
          end else if (!all_pass_r && all_step_r == 2'h1) begin
            all_step_r <= 2'h2;
            fl_cmd <= FC_ERASE_USER;
          end else if (all_pass_r && all_step_r == 2'h0) begin
            all_step_r <= 2'h1;
            fl_cmd <= FC_ZERO_PROT;
          end else if (!last_mac) begin
            all_step_r <= 2'h0;
            mac_r <= mac_r - MACRO_W'(1);
            fl_macro <= mac_r - MACRO_W'(1);
            fl_cmd <= all_pass_r ? FC_ERASE_PROT : FC_ERASE_USER;
          end else if (!all_pass_r) begin
            all_pass_r <= 1'b1;
            all_step_r <= 2'h0;
            mac_r <= MACRO_W'(MACROS - 1);
            fl_macro <= MACRO_W'(MACROS - 1);
            fl_cmd <= FC_ERASE_PROT;
          end else begin
            tmr_start_r <= 1'b0;
            fl_cmd <= FC_NONE;
            rc_r <= RC_OK;
            state_r <= S_RC_K1;
          end
        end
        // sum the calibration row and compare
        S_BOOT: begin
          if (iss_idx_r != BLOCK_BYTES) begin
            fl_rd <= 1'b1;
            fl_cmd <= FC_READ;
            fl_row <= ROW_CAL;
            fl_block <= '0;
            fl_byte <= iss_idx_r[5:0];
            iss_idx_r <= iss_idx_r + 7'h01;
          end
          if (rd_vld_r) begin
            out_idx_r <= out_idx_r + 6'h01;
            if (out_idx_r == CAL_SUM_LO) ref_r[7:0] <= fl_rdata;
            else if (out_idx_r == CAL_SUM_HI) ref_r[15:8] <= fl_rdata;
            else sum_r <= 16'(sum_r + {8'h00, fl_rdata});
            if (out_idx_r == LAST_BYTE) state_r <= S_BOOT_CHK;
          end
        end
        S_BOOT_CHK: begin
          fl_cmd <= FC_NONE;
          fl_row <= ROW_USER;
          acc_r <= FN_BOOT;
          if (sum_r != ref_r) begin
            rc_r <= RC_FATAL;
            halt_after_r <= 1'b1;
            state_r <= S_RC_K1;
          end else begin
            cpu_run <= 1'b1;
            rc_r <= RC_SWRESET;
            state_r <= soft_boot_r ? S_RC_K1 : S_IDLE;
          end
        end
        // return code into the first key byte, clear the second
        S_RC_K1: begin
          ram_we <= 1'b1;
          ram_addr <= 8'(PRM_BASE + {5'h00, PRM_FIRST_KEY_BYTE});
          ram_wdata <= rc_r;
          fl_cmd <= FC_NONE;
          state_r <= S_RC_K2;
        end
        S_RC_K2: begin
          ram_we <= 1'b1;
          ram_addr <= 8'(PRM_BASE + {5'h00, PRM_SECOND_KEY_BYTE});
          ram_wdata <= ZERO_BYTE;
          acc_r <= ZERO_BYTE;
          state_r <= halt_after_r ? S_HALT : S_IDLE;
        end
        S_HALT: begin
          cpu_halted <= 1'b1;
          cpu_run <= 1'b0;
        end
      endcase
    end
  end
endmodule // fbs_engine

/* File: fbs_pkg.sv */
package fbs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CALL = 8'h00;
  localparam logic [7:0] ADDR_SP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_HALT_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_RC_LSB = 8;
  localparam int ST_PERM_LSB = 16;
  localparam int ST_LVL_LSB = 20;
  localparam int ST_ACC_LSB = 24;
  // keys and parameter block
  localparam logic [7:0] FIRST_KEY_BYTE_VALUE = 8'h3A;
  localparam logic [7:0] SECOND_KEY_BYTE_OFFSET = 8'h03;
  localparam logic [7:0] PRM_BASE = 8'hF8;
  localparam logic [2:0] PRM_FIRST_KEY_BYTE = 3'h0;
  localparam logic [2:0] PRM_SECOND_KEY_BYTE = 3'h1;
  localparam logic [2:0] PRM_BLK = 3'h2;
  localparam logic [2:0] PRM_PTR = 3'h3;
  localparam logic [2:0] PRM_CLK = 3'h4;
  localparam logic [2:0] PRM_DLY = 3'h6;
  localparam logic [2:0] PRM_LAST = 3'h7;
  // service codes and return codes
  localparam logic [7:0] FN_BOOT = 8'h00;
  localparam logic [7:0] FN_READ = 8'h01;
  localparam logic [7:0] FN_WRITE = 8'h02;
  localparam logic [7:0] FN_ERASE = 8'h03;
  localparam logic [7:0] FN_ERASE_ALL = 8'h05;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_PROT = 8'h01;
  localparam logic [7:0] RC_SWRESET = 8'h02;
  localparam logic [7:0] RC_FATAL = 8'h03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // block geometry and calibration row layout
  localparam logic [5:0] LAST_BYTE = 6'h3F;
  localparam logic [5:0] CAL_SUM_LO = 6'h3E;
  localparam logic [5:0] CAL_SUM_HI = 6'h3F;
  localparam logic [6:0] BLOCK_BYTES = 7'h40;
  localparam int PULSE_SHIFT = 4;
  // protection levels and permission bits
  localparam logic [1:0] LVL_OPEN = 2'h0;
  localparam logic [1:0] LVL_RD_PROT = 2'h1;
  localparam logic [1:0] LVL_NO_EXT_WR = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  localparam int PERM_SR = 0;
  localparam int PERM_ER = 1;
  localparam int PERM_EW = 2;
  localparam int PERM_IW = 3;

  typedef enum logic [2:0] {
    FC_NONE, FC_READ, FC_PROG, FC_ERASE_BLK, FC_ERASE_USER, FC_ZERO_USER,
    FC_ERASE_PROT, FC_ZERO_PROT
  } fbs_fcmd_type;
  typedef enum logic [1:0] {ROW_USER, ROW_PROT, ROW_CAL} fbs_row_type;

  // two-bit level of a block out of its protection byte
  function automatic logic [1:0] fbs_level(input logic [7:0] pbyte, input logic [1:0] sub);
    fbs_level = pbyte[{sub, 1'b0} +: 2];
  endfunction

  // permission set {iw, ew, er, sr} granted by a level
  function automatic logic [3:0] fbs_perm(input logic [1:0] lvl);
    unique case (lvl)
      LVL_OPEN: fbs_perm = 4'hF;
      LVL_RD_PROT: fbs_perm = 4'h8;
      LVL_NO_EXT_WR: fbs_perm = 4'hB;
      LVL_FULL: fbs_perm = 4'h0;
    endcase
  endfunction
endpackage

/* File: fbs_pulse_timer.sv */
`timescale 1ns/100ps
module fbs_pulse_timer import fbs_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [7:0] div,
  input wire logic [7:0] dly,
  // status
  output logic pulse_on,
  output logic done
);
  typedef enum logic [1:0] {T_IDLE, T_DLY, T_PULSE} fbs_tphase_type;
  fbs_tphase_type phase_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] pulse_len;

  // pulse length scales with the divider parameter
  assign pulse_len = CNT_W'((CNT_W'(div) + CNT_W'(1)) << PULSE_SHIFT);
  assign pulse_on = (phase_r == T_PULSE);

  // settle delay, then the timed pulse
  always_ff @(posedge aclk) begin
    done <= 1'b0;
    if (!aresetn) begin
      phase_r <= T_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (phase_r)
        T_IDLE: if (start) begin
          phase_r <= T_DLY;
          cnt_r <= CNT_W'(dly);
        end
        T_DLY: if (cnt_r == '0) begin
          phase_r <= T_PULSE;
          cnt_r <= pulse_len - CNT_W'(1);
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
        T_PULSE: if (cnt_r == '0) begin
          phase_r <= T_IDLE;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      endcase
    end
  end
endmodule // fbs_pulse_timer

/* File: fbs_monitor.sv */
`timescale 1ns/100ps
module fbs_monitor import fbs_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  // far side
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic fl_rd,
  input wire logic fl_pulse,
  input wire fbs_fcmd_type fl_cmd,
  // processor state
  input wire logic cpu_halted
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write response handshake
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("b lost");
  b_drop_a: assert property (bvalid && bready |=> !bvalid && awready) else $error("b not released");
  // boot and halt
  boot_go_a: assert property ($rose(aresetn) |-> ##[0:16] fl_rd)
    else $error("no boot read");
  halt_keep_a: assert property (cpu_halted |=> cpu_halted)
    else $error("halt lost");
  halt_quiet_a: assert property (cpu_halted ##1 cpu_halted |-> !ram_we && !fl_rd && !fl_pulse)
    else $error("halted but busy");
  // program and erase pulses
  pulse_kind_a: assert property (fl_pulse |-> !(fl_cmd inside {FC_NONE, FC_READ}))
    else $error("pulse without op");
  pulse_len_a: assert property ($rose(fl_pulse) |-> $stable(fl_cmd) ##1 fl_pulse[*8])
    else $error("pulse short");
  // parameter block replies
  key_zero_a: assert property (ram_we && ram_addr == 8'hF9 |-> ram_wdata == ZERO_BYTE)
    else $error("second key not zero");
  rc_code_a: assert property (ram_we && ram_addr == 8'hF8 |-> ram_wdata <= RC_FATAL)
    else $error("bad return code");
  // main scenarios
  cover property ($rose(fl_pulse));
  cover property ($rose(cpu_halted));
  cover property (ram_we && ram_addr == 8'hF8 && ram_wdata == RC_PROT);
endmodule // fbs_monitor

bind fbs_engine fbs_monitor u_mon (.aclk, .aresetn, .awready, .bvalid, .bready, .ram_addr,
  .ram_wdata, .ram_we, .fl_rd, .fl_pulse, .fl_cmd, .cpu_halted);

/* File: fbs_far_model.sv */
`timescale 1ns/100ps
module fbs_far_model import fbs_pkg::*; #(
  parameter logic [7:0] ERASED = 8'hFF
) (
  // clock
  input wire logic aclk,
  // data ram
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [7:0] ram_rdata,
  // flash macro
  input wire logic fl_rd,
  input wire fbs_fcmd_type fl_cmd,
  input wire logic fl_pulse,
  input wire fbs_row_type fl_row,
  input wire logic [7:0] fl_block,
  input wire logic [5:0] fl_byte,
  input wire logic [7:0] fl_wdata,
  output logic [7:0] fl_rdata
);
  logic [7:0] ram [256];
  logic [7:0] usr [16384];
  logic [7:0] prt [64];
  logic [7:0] cal [64];
  logic pulse_d = 0;
  fbs_fcmd_type ops [$];
  initial ram_rdata = 0;
  initial fl_rdata = 0;
  // ram answers the cycle after a read, a moving value otherwise
  always @(posedge aclk) begin
    if (ram_we) ram[ram_addr] <= ram_wdata;
    ram_rdata <= ram_re ? ram[ram_addr] : ~ram_rdata;
  end
  // flash reads alike, one operation logged per pulse start
  always @(posedge aclk) begin
    pulse_d <= fl_pulse;
    fl_rdata <= !fl_rd ? ~fl_rdata : fl_row == ROW_PROT ? prt[fl_byte]
      : fl_row == ROW_CAL ? cal[fl_byte] : usr[{fl_block, fl_byte}];
    if (fl_pulse && !pulse_d) begin
      ops.push_back(fl_cmd);
      case (fl_cmd)
        FC_PROG: usr[{fl_block, fl_byte}] <= fl_wdata;
        FC_ERASE_BLK: for (int i = 0; i < 64; i++) usr[{fl_block, i[5:0]}] <= ERASED;
        FC_ERASE_USER: foreach (usr[i]) usr[i] <= ERASED;
        FC_ZERO_USER: foreach (usr[i]) usr[i] <= 8'h00;
        FC_ERASE_PROT: foreach (prt[i]) prt[i] <= ERASED;
        FC_ZERO_PROT: foreach (prt[i]) prt[i] <= 8'h00;
        default: ;
      endcase
    end
  end
endmodule // fbs_far_model

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top import fbs_pkg::*; ;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, sp, blk, ptr, fn;
  logic [31:0] wdata = 0, rdv, rdata;
  logic [1:0] rsp, lv, bresp, rresp;
  logic [15:0] sum;
  logic awready, wready, bvalid, arready, rvalid, ram_we, ram_re, fl_rd, fl_pulse;
  logic cpu_run, cpu_halted, fl_macro;
  logic [7:0] ram_addr, ram_wdata, ram_rdata, fl_block, fl_wdata, fl_rdata;
  logic [5:0] fl_byte;
  fbs_fcmd_type fl_cmd;
  fbs_row_type fl_row;
  int failures = 0, check_count = 0;
  fbs_fcmd_type eseq [5] = '{FC_ERASE_USER, FC_ZERO_USER, FC_ERASE_USER, FC_ERASE_PROT,
    FC_ZERO_PROT};
  // clock
  always #5 aclk = ~aclk;
  fbs_engine u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ram_addr, .ram_wdata, .ram_we, .ram_re, .ram_rdata, .fl_rd, .fl_cmd,
    .fl_pulse, .fl_row, .fl_macro, .fl_block, .fl_byte, .fl_wdata, .fl_rdata, .cpu_run,
    .cpu_halted);
  fbs_far_model u_far (.aclk, .ram_addr, .ram_wdata, .ram_we, .ram_re, .ram_rdata, .fl_rd,
    .fl_cmd, .fl_pulse, .fl_row, .fl_block, .fl_byte, .fl_wdata, .fl_rdata);
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bus write, each channel released at its own ready
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ad = 0;
    wd = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    // response left waiting one cycle before it is taken
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  // bus read
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rdv = rdata;
    rsp = rresp;
  endtask
  // reset, then the boot service must release the processor
  task restart;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 400 && cpu_run !== 1'b1; i++) @(posedge aclk);
    chk(cpu_run, 1);
  endtask
  // parameter block, call, wait until idle or halted
  task call(input logic [7:0] f, input logic [7:0] b, input logic [7:0] p, input bit bad);
    u_far.ram[8'hF8] = bad ? ~FIRST_KEY_BYTE_VALUE : FIRST_KEY_BYTE_VALUE;
    u_far.ram[8'hF9] = sp + SECOND_KEY_BYTE_OFFSET;
    u_far.ram[8'hFA] = b;
    u_far.ram[8'hFB] = p;
    u_far.ram[8'hFC] = 8'h00;
    u_far.ram[8'hFE] = 8'h56;
    wr(ADDR_CALL, {24'h0, f});
    do rd(ADDR_STATUS);
    while (rdv[ST_BUSY_BIT] === 1'b1 && rdv[ST_HALT_BIT] !== 1'b1);
  endtask
  // reads need the supervisory read right, writes and erases the internal write right
  function automatic bit allowed(logic [7:0] f, logic [1:0] l);
    return f == FN_READ ? (l == 2'h0 || l == 2'h2) : l != 2'h3;
  endfunction
  // main sequence
  initial begin
    void'($urandom(73));
    sum = 0;
    for (int i = 0; i < 62; i++) begin
      u_far.cal[i] = $urandom;
      sum += u_far.cal[i];
    end
    u_far.cal[62] = sum[7:0];
    u_far.cal[63] = sum[15:8];
    restart();
    sp = $urandom;
    wr(ADDR_SP, {24'h0, sp});
    chk(rsp, RESP_OKAY);
    rd(8'h0C);
    chk(rsp, RESP_SLVERR);
    // read, write and erase against every level, neighbours in the byte random
    for (int k = 0; k < 12; k++) begin
      fn = k % 3 + 1;
      lv = k % 4;
      blk = $urandom_range(127);
      ptr = $urandom_range(184);
      u_far.prt[blk[7:2]] = $urandom & ~(8'h03 << 2 * blk[1:0]) | lv << 2 * blk[1:0];
      for (int i = 0; i < 64; i++) begin
        u_far.usr[{blk, i[5:0]}] = $urandom;
        u_far.ram[ptr + i] = $urandom;
      end
      call(fn, blk, ptr, 0);
      chk(rdv[ST_LVL_LSB +: 2], lv);
      chk(u_far.ram[8'hF8], allowed(fn, lv) ? RC_OK : RC_PROT);
      chk(u_far.ram[8'hF9], ZERO_BYTE);
      rd(ADDR_CALL);
      chk(rdv[7:0], ZERO_BYTE);
      for (int i = 0; i < 64 && allowed(fn, lv); i++)
        chk(u_far.usr[{blk, i[5:0]}], fn == FN_ERASE ? u_far.ERASED : u_far.ram[ptr + i]);
    end
    // wipe a block: erase it, then program it with zeros
    u_far.prt[blk[7:2]] = 8'h00;
    call(FN_ERASE, blk, ptr, 0);
    chk(u_far.usr[{blk, 6'h00}], u_far.ERASED);
    for (int i = 0; i < 64; i++) u_far.ram[ptr + i] = 8'h00;
    call(FN_WRITE, blk, ptr, 0);
    for (int i = 0; i < 64; i++) chk(u_far.usr[{blk, i[5:0]}], 8'h00);
    // whole-array erase order
    u_far.ops.delete();
    call(FN_ERASE_ALL, 0, 0, 0);
    chk(u_far.ops.size(), 5);
    foreach (eseq[j]) chk(u_far.ops[j], eseq[j]);
    chk(u_far.prt[blk[7:2]], 8'h00);
    // soft boot ignores a broken key, a real call with one halts
    call(FN_BOOT, 0, 0, 1);
    chk(u_far.ram[8'hF8], RC_SWRESET);
    chk(cpu_halted, 0);
    call(FN_ERASE, 0, 0, 1);
    chk(cpu_halted, 1);
    restart();
    call(8'h04, 0, 0, 0);
    chk(cpu_halted, 1);
    report_and_stop();
  end
  // hang guard, well past the expected run length
  initial begin
    #1_000_000;
    failures++;
    report_and_stop();
  end
endmodule // tb_top
